// file: logic/strap_config_defs.vh
// Strap decoder constants: field codes and power-on defaults.
// Assumes inclusion by the strap decoder files only.
`ifndef STRAP_CONFIG_DEFS_VH
`define STRAP_CONFIG_DEFS_VH
`define STRAP_WIDTH 15
// Strap vector bit positions
`define S_LINKUP 0
`define S_AN_LO 1
`define S_AN_HI 2
`define S_MG_LO 3
`define S_MG_HI 4
`define S_START 5
`define S_P6_SPD 6
`define S_P6_SUB 7
`define S_P6_LO 8
`define S_P6_HI 9
`define S_P7_SPD 10
`define S_P7_SUB 11
`define S_P7_LO 12
`define S_P7_HI 13
`define S_INBAND 14
// Reset value of captured straps: all documented defaults
`define STRAP_DEFAULT 15'h003F
// Strap pin output enables, active low: all floating, all driven
`define STRAP_OE_FLOAT 15'h7FFF
`define STRAP_OE_DRIVE 15'h0000
// Autoneg/test field codes
`define AN_RSVD 2'h0
`define AN_FORCE100 2'h1
`define AN_NAND 2'h2
`define AN_ENABLE 2'h3
// Management selection codes
`define MG_MDIO 2'h0
`define MG_I2C 2'h1
`define MG_SPI 2'h2
// MAC port interface codes
`define IF_RGMII 2'h0
`define IF_RMII 2'h1
`define IF_RSVD 2'h2
`define IF_MII 2'h3
`endif

// file: logic/mac_port_decode.v
// One external MAC port strap decoder, registered outputs.
// Assumes straps are stable captured values.
`timescale 1ns/1ps
`include "strap_config_defs.vh"
module mac_port_decode (
  input wire sys_clk,
  input wire reset_n,
  input wire [1:0] if_sel,
  input wire submode,
  input wire speed,
  output reg [1:0] if_mode_q,
  output reg mii_mac_q,
  output reg refclk_out_en_q,
  output reg speed_100_q,
  output reg if_reserved_q
);
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      if_mode_q <= `IF_RGMII;
      mii_mac_q <= 1'b0;
      refclk_out_en_q <= 1'b0;
      speed_100_q <= 1'b0;
      if_reserved_q <= 1'b0;
    end else begin
      if_mode_q <= if_sel;
      // Submode only matters for MII and RMII
      mii_mac_q <= (if_sel == `IF_MII) & submode;
      refclk_out_en_q <= (if_sel == `IF_RMII) & ~submode;
      speed_100_q <= speed;
      if_reserved_q <= (if_sel == `IF_RSVD);
    end
  end
endmodule

// file: logic/strap_config_decoder.v
// Summary of operation
// - Strap pins float in reset, sampled at reset release, then driven.
// - Link-up strap 0 is fast link-up, 1 normal with crossover, autoneg set by its field.
// - Normal link-up autoneg field: reserved, forced 100 half, NAND test, on.
// - Fast link-up forces full duplex, autoneg and crossover off.
// - Fast link-up role strap: 0 slave with MDI-X, 1 master with MDI.
// - Fast link-up speed strap selects 1000BASE-T for both values.
// - Management field: 00 MDIO, 01 I2C, 1x SPI.
// - Startup strap 0 holds forwarding until software start bit is set.
// - First MAC port field: RGMII, RMII, reserved, MII.
// - First port submode: PHY or RMII clock out at 0, MAC or clock in at 1.
// - First port speed strap: 0 gigabit, 1 100 Mbps, board picks 100 on MII.
// - Second MAC port field: RGMII, RMII, reserved, MII.
// - Second port submode: PHY or RMII clock out at 0, MAC or clock in at 1.
// - Second port speed strap: 0 gigabit, 1 100 Mbps, board picks 100 on MII.
// - In-band management strap: 0 disabled, 1 enabled.
//
// Strap capture and switch configuration decoder, core clock domain.
// Assumes strap pins are stable around reset release; all inputs synchronous.
`timescale 1ns/1ps
`include "strap_config_defs.vh"
module strap_config_decoder (
  input wire sys_clk,
  input wire reset_n,
  input wire linkup_mode_strap,
  input wire autoneg_lo_or_role_strap,
  input wire autoneg_hi_or_speed_strap,
  input wire mgmt_sel_lo_strap,
  input wire mgmt_sel_hi_strap,
  input wire startup_forward_strap,
  input wire p6_speed_strap,
  input wire p6_submode_strap,
  input wire p6_if_lo_strap,
  input wire p6_if_hi_strap,
  input wire p7_speed_strap,
  input wire p7_submode_strap,
  input wire p7_if_lo_strap,
  input wire p7_if_hi_strap,
  input wire inband_mgmt_strap,
  input wire start_forward_bit,
  output reg [14:0] strap_pin_oe_n_q,
  output reg strap_valid_q,
  output reg fast_linkup_q,
  output reg autoneg_en_q,
  output reg auto_mdix_en_q,
  output reg full_duplex_q,
  output reg forced_100_q,
  output reg nand_tree_q,
  output reg autoneg_reserved_q,
  output reg gig_master_q,
  output reg mdix_q,
  output reg phy_speed_1000_q,
  output reg [1:0] mgmt_sel_q,
  output reg forward_en_q,
  output reg [1:0] p6_if_mode_q,
  output reg p6_mii_mac_q,
  output reg p6_refclk_out_en_q,
  output reg p6_speed_100_q,
  output reg p6_if_reserved_q,
  output reg [1:0] p7_if_mode_q,
  output reg p7_mii_mac_q,
  output reg p7_refclk_out_en_q,
  output reg p7_speed_100_q,
  output reg p7_if_reserved_q,
  output reg inband_access_q,
  output reg inband_i2c_conflict_q
);
  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  wire [`STRAP_WIDTH-1:0] strap_pins;
  reg [`STRAP_WIDTH-1:0] strap_q;
  reg captured_q;
  wire [1:0] an_field;
  wire [1:0] p6_if_w;
  wire [1:0] p7_if_w;
  wire p6_mac_w, p6_ref_w, p6_spd_w, p6_rsv_w;
  wire p7_mac_w, p7_ref_w, p7_spd_w, p7_rsv_w;

  assign strap_pins = {inband_mgmt_strap, p7_if_hi_strap, p7_if_lo_strap,
    p7_submode_strap, p7_speed_strap, p6_if_hi_strap, p6_if_lo_strap,
    p6_submode_strap, p6_speed_strap, startup_forward_strap,
    mgmt_sel_hi_strap, mgmt_sel_lo_strap, autoneg_hi_or_speed_strap,
    autoneg_lo_or_role_strap, linkup_mode_strap};

  // First clocked edge after release samples pins; later edges hold
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      strap_q <= `STRAP_DEFAULT;
      captured_q <= 1'b0;
      strap_pin_oe_n_q <= `STRAP_OE_FLOAT;
    end else begin
      if (!captured_q) begin
        strap_q <= strap_pins;
      end
      captured_q <= 1'b1;
      // Pins turn to driven outputs once sampled
      strap_pin_oe_n_q <= captured_q ? `STRAP_OE_DRIVE :
        `STRAP_OE_FLOAT;
    end
  end

  // ----------------------------------------------------------------
  // PHY and switch-wide decode
  // ----------------------------------------------------------------
  assign an_field = {strap_q[`S_AN_HI], strap_q[`S_AN_LO]};

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      strap_valid_q <= 1'b0;
      fast_linkup_q <= 1'b0;
      autoneg_en_q <= 1'b1;
      auto_mdix_en_q <= 1'b1;
      full_duplex_q <= 1'b1;
      forced_100_q <= 1'b0;
      nand_tree_q <= 1'b0;
      autoneg_reserved_q <= 1'b0;
      gig_master_q <= 1'b1;
      mdix_q <= 1'b0;
      phy_speed_1000_q <= 1'b1;
      mgmt_sel_q <= `MG_SPI;
      forward_en_q <= 1'b0;
      inband_access_q <= 1'b0;
      inband_i2c_conflict_q <= 1'b0;
    end else begin
      strap_valid_q <= captured_q;
      fast_linkup_q <= ~strap_q[`S_LINKUP];
      if (!strap_q[`S_LINKUP]) begin
        // Fast link-up ignores the autoneg field
        autoneg_en_q <= 1'b0;
        auto_mdix_en_q <= 1'b0;
        full_duplex_q <= 1'b1;
        forced_100_q <= 1'b0;
        nand_tree_q <= 1'b0;
        autoneg_reserved_q <= 1'b0;
        gig_master_q <= strap_q[`S_AN_LO];
        mdix_q <= ~strap_q[`S_AN_LO];
        // Both strap values give gigabit
        phy_speed_1000_q <= 1'b1;
      end else begin
        auto_mdix_en_q <= 1'b1;
        autoneg_en_q <= (an_field == `AN_ENABLE);
        forced_100_q <= (an_field == `AN_FORCE100);
        full_duplex_q <= (an_field != `AN_FORCE100);
        nand_tree_q <= (an_field == `AN_NAND);
        autoneg_reserved_q <= (an_field == `AN_RSVD);
        gig_master_q <= 1'b1;
        mdix_q <= 1'b0;
        phy_speed_1000_q <= (an_field != `AN_FORCE100);
      end
      if (strap_q[`S_MG_HI]) begin
        mgmt_sel_q <= `MG_SPI;
      end else begin
        mgmt_sel_q <= strap_q[`S_MG_LO] ? `MG_I2C : `MG_MDIO;
      end
      // Forwarding waits for software when startup strap is low
      forward_en_q <= captured_q &
        (strap_q[`S_START] | start_forward_bit);
      inband_access_q <= strap_q[`S_INBAND];
      inband_i2c_conflict_q <= strap_q[`S_INBAND] &
        ~strap_q[`S_MG_HI] & strap_q[`S_MG_LO];
    end
  end

  // ----------------------------------------------------------------
  // External MAC ports
  // ----------------------------------------------------------------
  mac_port_decode u_p6 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .if_sel({strap_q[`S_P6_HI], strap_q[`S_P6_LO]}),
    .submode(strap_q[`S_P6_SUB]),
    .speed(strap_q[`S_P6_SPD]),
    .if_mode_q(p6_if_w),
    .mii_mac_q(p6_mac_w),
    .refclk_out_en_q(p6_ref_w),
    .speed_100_q(p6_spd_w),
    .if_reserved_q(p6_rsv_w)
  );

  mac_port_decode u_p7 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .if_sel({strap_q[`S_P7_HI], strap_q[`S_P7_LO]}),
    .submode(strap_q[`S_P7_SUB]),
    .speed(strap_q[`S_P7_SPD]),
    .if_mode_q(p7_if_w),
    .mii_mac_q(p7_mac_w),
    .refclk_out_en_q(p7_ref_w),
    .speed_100_q(p7_spd_w),
    .if_reserved_q(p7_rsv_w)
  );

  // Output stage puts every MAC port output on a second flip-flop
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      p6_if_mode_q <= `IF_RGMII;
      p6_mii_mac_q <= 1'b0;
      p6_refclk_out_en_q <= 1'b0;
      p6_speed_100_q <= 1'b0;
      p6_if_reserved_q <= 1'b0;
      p7_if_mode_q <= `IF_RGMII;
      p7_mii_mac_q <= 1'b0;
      p7_refclk_out_en_q <= 1'b0;
      p7_speed_100_q <= 1'b0;
      p7_if_reserved_q <= 1'b0;
    end else begin
      p6_if_mode_q <= p6_if_w;
      p6_mii_mac_q <= p6_mac_w;
      p6_refclk_out_en_q <= p6_ref_w;
      p6_speed_100_q <= p6_spd_w;
      p6_if_reserved_q <= p6_rsv_w;
      p7_if_mode_q <= p7_if_w;
      p7_mii_mac_q <= p7_mac_w;
      p7_refclk_out_en_q <= p7_ref_w;
      p7_speed_100_q <= p7_spd_w;
      p7_if_reserved_q <= p7_rsv_w;
    end
  end
endmodule

// file: dv/strap_config_checker.sv
// Port checker for the strap decoder.
// Assumes it is bound to strap_config_decoder.
`timescale 1ns/1ps
module strap_config_checker (
  input wire sys_clk,
  input wire reset_n,
  input wire start_forward_bit,
  input wire [14:0] strap_pin_oe_n_q,
  input wire strap_valid_q,
  input wire fast_linkup_q,
  input wire autoneg_en_q,
  input wire auto_mdix_en_q,
  input wire full_duplex_q,
  input wire gig_master_q,
  input wire mdix_q,
  input wire phy_speed_1000_q,
  input wire [1:0] mgmt_sel_q,
  input wire forward_en_q,
  input wire inband_access_q,
  input wire inband_i2c_conflict_q,
  input wire [1:0] p6_if_mode_q,
  input wire p6_if_reserved_q,
  input wire [1:0] p7_if_mode_q,
  input wire p7_refclk_out_en_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire v = strap_valid_q;
  wire fl = v && fast_linkup_q;
  AST_PINS_HIZ: assert property (disable iff (1'b0)
    !reset_n |=> strap_pin_oe_n_q == 15'h7FFF) else $error("pins driven");
  AST_PINS_DRIVEN: assert property (
    v |-> strap_pin_oe_n_q == 15'h0000) else $error("pins not driven");
  AST_VALID_TIME: assert property (
    $rose(reset_n) |-> !v ##1 !v ##1 v) else $error("valid late");
  AST_STATIC: assert property (
    v && $past(v, 2) |-> $stable(fast_linkup_q) && $stable(mgmt_sel_q)
    && $stable(p6_if_mode_q) && $stable(inband_access_q))
    else $error("config moved");
  AST_FAST_PHY: assert property (
    fl |-> !autoneg_en_q && !auto_mdix_en_q && full_duplex_q)
    else $error("fast link-up wrong");
  AST_FAST_ROLE: assert property (
    fl |-> mdix_q != gig_master_q && phy_speed_1000_q)
    else $error("fast role wrong");
  AST_FWD_START: assert property (
    v && start_forward_bit |=> forward_en_q) else $error("no forward");
  AST_MGMT_CODE: assert property (
    mgmt_sel_q != 2'h3) else $error("bad mgmt code");
  AST_CONFLICT: assert property (
    v |-> inband_i2c_conflict_q == (inband_access_q && mgmt_sel_q == 2'h1))
    else $error("conflict flag wrong");
  AST_P6_RSVD: assert property (
    p6_if_reserved_q == (p6_if_mode_q == 2'h2)) else $error("p6 reserved");
  AST_P7_REFCLK: assert property (
    p7_refclk_out_en_q |-> p7_if_mode_q == 2'h1) else $error("p7 refclk");
  cover property (fl);
  cover property (inband_i2c_conflict_q);
  cover property (v && p6_if_mode_q == 2'h3);
endmodule
bind strap_config_decoder strap_config_checker chk_u (.*);

// file: dv/board_straps.sv
// Board pull resistors on the strap pins.
// Assumes oe_n low means the device drives the pin.
`timescale 1ns/1ps
module board_straps (
  input wire [14:0] pull,
  input wire [14:0] oe_n,
  input wire break_rule,
  output wire [14:0] pin
);
  // Board never pairs in-band management with I2C unless told to
  wire bad = pull[4:3] == 2'h1 && !break_rule;
  // MII and RMII ports (mode low bit set) are strapped to 100 Mbps
  wire [14:0] lvl = {pull[14] & ~bad, pull[13:11],
    pull[10] | (pull[12] & !break_rule), pull[9:7],
    pull[6] | (pull[8] & !break_rule), pull[5:0]};
  // Driven pins show the inverted pull level
  assign pin = ~(oe_n ^ lvl);
endmodule

// file: dv/strap_config_decoder_test.sv
// Self-checking bench for the strap decoder.
// Assumes the board model and the bound checker.
`timescale 1ns/1ps
module strap_config_decoder_test;
  reg sys_clk = 1'b0;
  reg reset_n = 1'b0;
  reg start_forward_bit = 1'b0;
  reg brk = 1'b0;
  reg [14:0] pull = 15'h003F;
  reg [14:0] w;
  wire [14:0] pin;
  wire [14:0] strap_pin_oe_n_q;
  wire [1:0] mgmt_sel_q, p6_if_mode_q, p7_if_mode_q;
  wire strap_valid_q, fast_linkup_q, autoneg_en_q, auto_mdix_en_q,
    full_duplex_q, forced_100_q, nand_tree_q, autoneg_reserved_q,
    gig_master_q, mdix_q, phy_speed_1000_q, forward_en_q,
    p6_mii_mac_q, p6_refclk_out_en_q, p6_speed_100_q, p6_if_reserved_q,
    p7_mii_mac_q, p7_refclk_out_en_q, p7_speed_100_q, p7_if_reserved_q,
    inband_access_q, inband_i2c_conflict_q;
  integer n_errors = 0;
  integer checked = 0;
  integer cyc = 0;
  integer i;
  wire [13:0] phy = {fast_linkup_q, autoneg_en_q, auto_mdix_en_q,
    full_duplex_q, forced_100_q, nand_tree_q, autoneg_reserved_q,
    gig_master_q, mdix_q, phy_speed_1000_q, mgmt_sel_q, inband_access_q,
    inband_i2c_conflict_q};
  wire [5:0] p6 = {p6_if_mode_q, p6_mii_mac_q, p6_refclk_out_en_q,
    p6_speed_100_q, p6_if_reserved_q};
  wire [5:0] p7 = {p7_if_mode_q, p7_mii_mac_q, p7_refclk_out_en_q,
    p7_speed_100_q, p7_if_reserved_q};
  board_straps brd_u (.pull(pull), .oe_n(strap_pin_oe_n_q),
    .break_rule(brk), .pin(pin));
  strap_config_decoder dut_u (.linkup_mode_strap(pin[0]),
    .autoneg_lo_or_role_strap(pin[1]), .autoneg_hi_or_speed_strap(pin[2]),
    .mgmt_sel_lo_strap(pin[3]), .mgmt_sel_hi_strap(pin[4]),
    .startup_forward_strap(pin[5]), .p6_speed_strap(pin[6]),
    .p6_submode_strap(pin[7]), .p6_if_lo_strap(pin[8]),
    .p6_if_hi_strap(pin[9]), .p7_speed_strap(pin[10]),
    .p7_submode_strap(pin[11]), .p7_if_lo_strap(pin[12]),
    .p7_if_hi_strap(pin[13]), .inband_mgmt_strap(pin[14]), .*);
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  function [13:0] exp_phy(input [14:0] s);
    reg [1:0] a, m;
    begin
      a = s[2:1];
      m = s[4] ? 2'h2 : {1'b0, s[3]};
      if (!s[0])
        exp_phy = {7'b1001000, s[1], !s[1], 1'b1, m, s[14], s[14] && m == 1};
      else
        exp_phy = {1'b0, a == 3, 1'b1, a != 1, a == 1, a == 2, a == 0,
          2'b10, a != 1, m, s[14], s[14] && m == 1};
    end
  endfunction
  function [5:0] exp_port(input [3:0] p);
    exp_port = {p[3:2], p[3:2] == 3 && p[1], p[3:2] == 1 && !p[1], p[0],
      p[3:2] == 2};
  endfunction
  task check(input [31:0] seen, input [31:0] want);
    begin
      checked = checked + 1;
      if (seen !== want) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
    end
  endtask
  task run(input [14:0] v, input b);
    reg [14:0] s;
    begin
      pull = v;
      brk = b;
      reset_n = 1'b0;
      s = {v[14] & ~(v[4:3] == 2'h1 && !b), v[13:11],
        v[10] | (v[12] & !b), v[9:7], v[6] | (v[8] & !b), v[5:0]};
      repeat (2) @(posedge sys_clk);
      #2 check({strap_valid_q, strap_pin_oe_n_q}, 16'h7FFF);
      reset_n = 1'b1;
      repeat (2) @(posedge sys_clk);
      #2 check({strap_valid_q, strap_pin_oe_n_q}, 16'h8000);
      check(phy, exp_phy(s));
      check(forward_en_q, s[5]);
      @(posedge sys_clk);
      #2 check({p7, p6}, {exp_port(s[13:10]), exp_port(s[9:6])});
      pull = ~v;
      start_forward_bit = 1'b1;
      @(posedge sys_clk);
      #2 check(forward_en_q, 1'b1);
      check({phy, p7, p6}, {exp_phy(s), exp_port(s[13:10]),
        exp_port(s[9:6])});
      start_forward_bit = 1'b0;
      @(posedge sys_clk);
      #2 check(forward_en_q, s[5]);
      $display("test done, straps %h", v);
    end
  endtask
  task results;
    begin
      $display("checks %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    w = 15'($urandom(46));
    run(15'h003F, 1'b0);
    for (i = 0; i < 16; i = i + 1) begin
      w = {i[1] ^ i[3], i[3:0], ~i[3:0], 1'b1, i[1:0], i[3:2], i[0]};
      run(w, 1'b0);
    end
    run(15'h4029, 1'b1);
    for (i = 0; i < 20; i = i + 1) begin
      w = 15'($urandom);
      run(w, 1'b0);
    end
    results;
  end
endmodule
